// ===== logic/cnsl_pkg.sv
// Shared constants and carrier types for the slave node control
package cnsl_pkg;
	localparam int PD_BYTES = 8;
	localparam int SDO_VAL_BYTES = 4;
	localparam int CLK_MHZ = 100;
	localparam int TIMER_TICK_US = 1;
	localparam int TICK_CYCLES = TIMER_TICK_US * CLK_MHZ;
	localparam logic [15:0] ADDR_BASE_MASTER = 16'd1000;
	localparam logic [15:0] ADDR_BASE_FIRST = 16'd1001;
	localparam logic [15:0] OBJ_TPDO_PAR_LO = 16'h1800;
	localparam logic [15:0] OBJ_TPDO_PAR_HI = 16'h1803;
	localparam logic [15:0] OBJ_HEARTBEAT = 16'h1017;
	localparam logic [15:0] OBJ_GUARD_TIME = 16'h100c;
	localparam logic [15:0] OBJ_LIFE_FACTOR = 16'h100d;
	localparam logic [15:0] OBJ_INPUTS = 16'h2000;
	localparam logic [15:0] OBJ_OUTPUTS = 16'h2200;
	localparam logic [7:0] SDO_ERR_CODE = 8'h80;
	localparam logic [7:0] SDO_WR_ACK = 8'h60;
	localparam logic [7:0] SDO_RD_ACK = 8'h43;
	localparam logic [15:0] RESET_TIMER = 16'h0000;

	typedef enum logic [2:0] {
		NMT_START_INPUT,
		NMT_START_OUTPUT,
		NMT_TO_PREOP,
		NMT_RESET_NODE,
		NMT_NONE
	} cnsl_cmd_type;

	typedef enum logic [1:0] {
		TX_KIND_PDO,
		TX_KIND_SDO,
		TX_KIND_STATE
	} cnsl_kind_type;

	typedef struct packed {
		logic [15:0] index;
		logic [7:0] subindex;
		logic write;
		logic [31:0] value;
	} cnsl_sdo_type;

	typedef struct packed {
		cnsl_kind_type kind;
		logic [63:0] data;
	} cnsl_frame_type;

	typedef enum logic [1:0] {
		TRIG_EVENT,
		TRIG_SYNC,
		TRIG_TIMER,
		TRIG_REMOTE
	} cnsl_trig_type;
endpackage : cnsl_pkg

// ===== logic/cnsl_skid.sv
// Two-entry buffer between frame source and the bus transmitter
`timescale 1ns/1ps
module cnsl_skid
	import cnsl_pkg::*;
#(
	parameter int WIDTH = 66
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] mem_q [2];
	logic wr_q, rd_q;
	logic [1:0] cnt_q;
	wire push = in_valid_in && (cnt_q != 2'd2);
	wire pop = out_ready_in && (cnt_q != 2'd0);

	assign in_ready_out = (cnt_q != 2'd2);
	assign out_valid_out = (cnt_q != 2'd0);
	assign out_data_out = mem_q[rd_q];

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			cnt_q <= 2'd0;
		end else begin
			if (push) wr_q <= ~wr_q;
			if (pop) rd_q <= ~rd_q;
			cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) mem_q[wr_q] <= in_data_in;
	end

	chk_skid_no_overflow: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) cnt_q <= 2'd2)
		else $error("buffer count beyond two");
endmodule : cnsl_skid

// ===== logic/cnsl_timer.sv
// Periodic event timer counted in microsecond ticks
`timescale 1ns/1ps
module cnsl_timer
	import cnsl_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic tick_in,
	input wire logic enable_in,
	input wire logic [15:0] period_in,
	output logic expire_out
);
	logic [15:0] cnt_q;
	wire run = enable_in && (period_in != 16'h0000);
	wire hit = run && tick_in && (cnt_q + 16'h0001 >= period_in);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_q <= RESET_TIMER;
			expire_out <= 1'b0;
		end else begin
			expire_out <= hit;
			if (!run || hit) cnt_q <= 16'h0000;
			else if (tick_in) cnt_q <= cnt_q + 16'h0001;
		end
	end
endmodule : cnsl_timer

// ===== logic/cnsl_node.sv
// Slave node control: state sequence, service data, process data, monitoring
// Notes on behaviour
// - Initialisation: no communication with master
// - Pre-operational: service data only, no process
// - Start-input enters safe-op, no inputs sent
// - Safe-op ignores outputs, serves service data
// - Start-output: operational, confirm after received data
// - Activation failure: stay safe-op, flag error
// - Slave only, never issues master commands
// - Process images fixed at eight bytes
// - One object per service transfer
// - Four value bytes per service telegram
// - Every service transfer gets a response, except one taken beside a state frame or while the buffer is full
// - Process telegram at most eight bytes
// - Event mode sends on input change
// - Remote frame request gets data
// - Sync mode samples on SYNC, then sends
// - Timer mode sends when period elapses
// - Heartbeat sends node state periodically
// - Guarding query answered with node state
`timescale 1ns/1ps
module cnsl_node
	import cnsl_pkg::*;
#(
	parameter int ACT_WAIT = 1000
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	// Master commands, one-cycle pulses from the frame receiver
	input wire logic cmd_valid_in,
	input wire cnsl_cmd_type cmd_in,
	input wire logic addr_valid_in,
	input wire logic [15:0] addr_in,
	input wire logic sdo_valid_in,
	input wire cnsl_sdo_type sdo_in,
	input wire logic rpdo_valid_in,
	input wire logic [63:0] rpdo_in,
	input wire logic sync_in,
	input wire logic rtr_pdo_in,
	input wire logic rtr_guard_in,
	input wire logic out_act_ok_in,
	input wire logic [63:0] tx_image_in,
	input wire logic tx_ready_in,
	output logic tx_valid_out,
	output cnsl_frame_type tx_frame_out,
	output logic [63:0] rx_image_out,
	output logic [15:0] station_addr_out,
	output logic [1:0] node_state_out,
	output logic op_confirm_out,
	output logic error_out
);
	typedef enum logic [1:0] {
		ST_INIT,
		ST_PREOP,
		ST_SAFEOP,
		ST_OP
	} cnsl_state_type;

	////////////////////////////////////////////////////////////////////////
	// Configuration objects held locally
	cnsl_state_type state_q, state_d;
	cnsl_trig_type trig_q;
	logic [15:0] event_period_q, hb_period_q, guard_time_q;
	logic [7:0] life_factor_q;
	logic [15:0] station_q;
	logic [63:0] rx_q, sampled_q, last_tx_q;
	logic syn_pend_q;
	logic op_pend_q, op_conf_q, err_q, toggle_q;
	logic [15:0] act_cnt_q;
	logic [6:0] tick_cnt_q;
	logic tick_q;

	wire in_init = (state_q == ST_INIT);
	wire can_pdo = (state_q == ST_OP);
	wire can_sdo = !in_init;

	// Decoded service access
	wire sdo_take = sdo_valid_in && can_sdo;
	wire sdo_wr = sdo_take && sdo_in.write;
	wire hit_hb = (sdo_in.index == OBJ_HEARTBEAT);
	wire hit_gt = (sdo_in.index == OBJ_GUARD_TIME);
	wire hit_lf = (sdo_in.index == OBJ_LIFE_FACTOR);
	wire hit_tp = (sdo_in.index >= OBJ_TPDO_PAR_LO) &&
		(sdo_in.index <= OBJ_TPDO_PAR_HI);
	wire hit_in = (sdo_in.index == OBJ_INPUTS);
	wire hit_out = (sdo_in.index == OBJ_OUTPUTS);
	wire known = hit_hb || hit_gt || hit_lf || hit_tp || hit_in || hit_out;

	function automatic logic [31:0] rd_value(input logic [15:0] idx,
		input logic [7:0] sub);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (idx == OBJ_HEARTBEAT) v = {16'h0000, hb_period_q};
		else if (idx == OBJ_GUARD_TIME) v = {16'h0000, guard_time_q};
		else if (idx == OBJ_LIFE_FACTOR) v = {24'h000000, life_factor_q};
		else if (idx == OBJ_INPUTS) v = sub[0] ? rx_q[63:32] : rx_q[31:0];
		else if (idx == OBJ_OUTPUTS)
			v = sub[0] ? tx_image_in[63:32] : tx_image_in[31:0];
		else if (sub == 8'h05) v = {16'h0000, event_period_q};
		else if (sub == 8'h02) v = {30'h0, trig_q};
		return v;
	endfunction : rd_value

	////////////////////////////////////////////////////////////////////////
	// State sequence
	wire go_preop = cmd_valid_in && cmd_in == NMT_TO_PREOP;
	wire go_safe = cmd_valid_in && cmd_in == NMT_START_INPUT;
	wire go_op = cmd_valid_in && cmd_in == NMT_START_OUTPUT;
	wire go_reset = cmd_valid_in && cmd_in == NMT_RESET_NODE;
	wire act_fail = op_pend_q && (act_cnt_q == 16'h0000) && !out_act_ok_in;

	always_comb begin
		state_d = state_q;
		if (go_reset) state_d = ST_INIT;
		else begin
			case (state_q)
				ST_INIT: begin
					// Address must be valid in the same cycle as the pre-op command to leave init
					if (go_preop && addr_valid_in) state_d = ST_PREOP;
				end
				ST_PREOP: begin
					if (go_safe) state_d = ST_SAFEOP;
				end
				ST_SAFEOP: begin
					if (op_pend_q && out_act_ok_in) state_d = ST_OP;
					// Return to pre-op is held off while an activation is pending
					else if (go_preop && !op_pend_q) state_d = ST_PREOP;
				end
				ST_OP: begin
					if (go_preop) state_d = ST_PREOP;
					else if (go_safe) state_d = ST_SAFEOP;
				end
				default: state_d = ST_INIT;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) state_q <= ST_INIT;
		else state_q <= state_d;
	end

	// Pending activation and its watchdog
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			op_pend_q <= 1'b0;
			act_cnt_q <= 16'h0000;
			err_q <= 1'b0;
		end else begin
			if (go_op && state_q == ST_SAFEOP && !op_pend_q) begin
				op_pend_q <= 1'b1;
				act_cnt_q <= 16'(ACT_WAIT);
				err_q <= 1'b0;
			end else if (op_pend_q && (out_act_ok_in || go_reset)) begin
				op_pend_q <= 1'b0;
			end else if (act_fail) begin
				op_pend_q <= 1'b0;
				err_q <= 1'b1;
			end else if (op_pend_q) begin
				act_cnt_q <= act_cnt_q - 16'h0001;
			end
			// A failure beside a node reset stays visible
			if (act_fail) err_q <= 1'b1;
			else if (go_reset) err_q <= 1'b0;
		end
	end

	// Confirmation waits for the first received process data
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) op_conf_q <= 1'b0;
		else if (state_q != ST_OP) op_conf_q <= 1'b0;
		else if (rpdo_valid_in) op_conf_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Address, configuration and receive image
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			station_q <= 16'h0000;
			hb_period_q <= RESET_TIMER;
			guard_time_q <= RESET_TIMER;
			life_factor_q <= 8'h00;
			event_period_q <= RESET_TIMER;
			trig_q <= TRIG_EVENT;
			rx_q <= 64'h0;
		end else begin
			if (in_init && addr_valid_in) station_q <= addr_in;
			if (sdo_wr && hit_hb) hb_period_q <= sdo_in.value[15:0];
			if (sdo_wr && hit_gt) guard_time_q <= sdo_in.value[15:0];
			if (sdo_wr && hit_lf) life_factor_q <= sdo_in.value[7:0];
			if (sdo_wr && hit_tp && sdo_in.subindex == 8'h05)
				event_period_q <= sdo_in.value[15:0];
			if (sdo_wr && hit_tp && sdo_in.subindex == 8'h02)
				trig_q <= cnsl_trig_type'(sdo_in.value[1:0]);
			// Outputs from the master count only when operational
			if (rpdo_valid_in && can_pdo) rx_q <= rpdo_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Microsecond tick and timers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_cnt_q <= 7'd0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == 7'(TICK_CYCLES - 1));
			if (tick_cnt_q == 7'(TICK_CYCLES - 1)) tick_cnt_q <= 7'd0;
			else tick_cnt_q <= tick_cnt_q + 7'd1;
		end
	end

	logic ev_exp, hb_exp;
	cnsl_timer u_event_timer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick_q),
		.enable_in(can_pdo && trig_q == TRIG_TIMER),
		.period_in(event_period_q),
		.expire_out(ev_exp)
	);
	cnsl_timer u_heartbeat_timer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.tick_in(tick_q),
		.enable_in(!in_init),
		.period_in(hb_period_q),
		.expire_out(hb_exp)
	);

	////////////////////////////////////////////////////////////////////////
	// Transmit request selection; state frames first, then service, process
	wire changed = (tx_image_in != last_tx_q);
	wire want_ev = can_pdo && trig_q == TRIG_EVENT && changed;
	wire want_rtr = can_pdo && rtr_pdo_in;
	wire want_tim = ev_exp && can_pdo;
	wire want_syn = can_pdo && trig_q == TRIG_SYNC && sync_in;
	// A sample that lost its slot to a state or service frame waits here
	wire syn_send = can_pdo && (want_syn || syn_pend_q);
	wire want_pdo = want_ev || want_rtr || want_tim || syn_send;
	wire want_state = hb_exp || (rtr_guard_in && !in_init);
	logic [7:0] st_code;
	assign st_code = (state_q == ST_OP) ? 8'h05 :
		(state_q == ST_PREOP) ? 8'h7f : (state_q == ST_SAFEOP) ? 8'h04 :
		8'h00;
	wire [7:0] sdo_cmd = !known ? SDO_ERR_CODE :
		sdo_in.write ? SDO_WR_ACK : SDO_RD_ACK;
	wire [31:0] sdo_val = (known && !sdo_in.write) ?
		rd_value(sdo_in.index, sdo_in.subindex) : 32'h0000_0000;
	// Echoes index and sub-index, four value bytes follow
	wire [63:0] sdo_resp = {sdo_val, sdo_in.subindex, sdo_in.index,
		sdo_cmd};

	logic buf_ready, src_valid;
	cnsl_frame_type src_frame;
	assign src_valid = want_state || sdo_take || want_pdo;
	// Samples taken on SYNC go out through the buffer with the rest
	assign src_frame.kind = want_state ? TX_KIND_STATE :
		sdo_take ? TX_KIND_SDO : TX_KIND_PDO;
	assign src_frame.data = want_state ? {56'h0, toggle_q, st_code[6:0]} :
		sdo_take ? sdo_resp :
		((syn_pend_q && !want_syn) ? sampled_q : tx_image_in);

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_tx_q <= 64'h0;
			sampled_q <= 64'h0;
			syn_pend_q <= 1'b0;
			toggle_q <= 1'b0;
		end else begin
			if (want_syn) sampled_q <= tx_image_in;
			syn_pend_q <= syn_send &&
				!(buf_ready && !want_state && !sdo_take);
			if (src_valid && buf_ready && !want_state && !sdo_take)
				last_tx_q <= tx_image_in;
			if (rtr_guard_in && !in_init && buf_ready) toggle_q <= ~toggle_q;
		end
	end

	logic buf_valid;
	cnsl_frame_type buf_frame;
	cnsl_skid #(
		.WIDTH($bits(cnsl_frame_type))
	) u_tx_buf (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.in_valid_in(src_valid),
		.in_ready_out(buf_ready),
		.in_data_in(src_frame),
		.out_valid_out(buf_valid),
		.out_ready_in(tx_ready_in && tx_valid_out),
		.out_data_out(buf_frame)
	);

	// Registered outputs; the device only answers, never commands
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tx_valid_out <= 1'b0;
			tx_frame_out <= '0;
			rx_image_out <= 64'h0;
			station_addr_out <= 16'h0000;
			node_state_out <= 2'b00;
			op_confirm_out <= 1'b0;
			error_out <= 1'b0;
		end else begin
			if (!tx_valid_out || tx_ready_in) begin
				tx_valid_out <= buf_valid && !(tx_valid_out && tx_ready_in);
				if (buf_valid) tx_frame_out <= buf_frame;
			end
			rx_image_out <= rx_q;
			station_addr_out <= station_q;
			node_state_out <= state_q;
			op_confirm_out <= op_conf_q;
			error_out <= err_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	chk_init_no_sdo: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) in_init |-> !sdo_take)
		else $error("service access taken during init");
	chk_preop_no_pdo: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) (state_q != ST_OP) |-> !want_pdo)
		else $error("process data outside operational");
	chk_safe_entry: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		(state_q == ST_PREOP && go_safe && !go_reset)
		|=> state_q == ST_SAFEOP)
		else $error("start input did not enter safe-op");
	chk_safe_ignore_rx: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) (state_q == ST_SAFEOP && rpdo_valid_in)
		|=> $stable(rx_q))
		else $error("safe-op took output data");
	chk_confirm_wait: assert property (@(posedge clk_in)
		disable iff (!reset_n_in)
		$rose(op_conf_q) |-> $past(rpdo_valid_in))
		else $error("confirm before received data");
	chk_fail_error: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) act_fail && !go_reset
		|=> err_q && state_q == ST_SAFEOP)
		else $error("activation failure not flagged");
	chk_slave_only: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) tx_valid_out |-> tx_frame_out.kind inside
		{TX_KIND_PDO, TX_KIND_SDO, TX_KIND_STATE})
		else $error("frame kind outside slave set");
	chk_sdo_answer: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) sdo_take && !want_state
		|-> src_valid && src_frame.kind == TX_KIND_SDO)
		else $error("service transfer without answer");
	chk_sync_kept: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) want_syn && (want_state || sdo_take)
		|=> syn_pend_q && sampled_q == $past(tx_image_in))
		else $error("sync sample lost");
	chk_reset_no_skip: assert property (@(posedge clk_in)
		disable iff (!reset_n_in) (state_q == ST_INIT)
		|=> state_q inside {ST_INIT, ST_PREOP})
		else $error("init skipped a state");
endmodule : cnsl_node

// ===== sim/cnsl_master_model.sv
// Master-side frame sink for the slave node control
`timescale 1ns/1ps
module cnsl_master_model
	import cnsl_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic stall_in,
	input wire logic tx_valid_in,
	input wire cnsl_frame_type tx_frame_in,
	output logic tx_ready_out,
	output int bad_kind_out
);
	cnsl_frame_type frames[$];
	initial begin
		tx_ready_out = 1'b0;
		bad_kind_out = 0;
	end
	// Ready moves after the falling edge, away from sampling
	always @(negedge clk_in) begin
		tx_ready_out <= reset_n_in & ~stall_in;
	end
	always @(posedge clk_in) begin
		if (reset_n_in && tx_valid_in && tx_ready_out) begin
			frames.push_back(tx_frame_in);
			if (tx_frame_in.kind > TX_KIND_STATE) begin
				bad_kind_out <= bad_kind_out + 1;
			end
		end
	end
endmodule : cnsl_master_model

// ===== sim/tb_cnsl_node.sv
// Self-checking bench for the slave node control
`timescale 1ns/1ps
module tb_cnsl_node;
	import cnsl_pkg::*;
	localparam int ACT = 10;
	logic clk_in, reset_n_in, cmd_valid_in, addr_valid_in, sdo_valid_in;
	logic rpdo_valid_in, sync_in, rtr_pdo_in, rtr_guard_in, out_act_ok_in;
	logic tx_ready_in, tx_valid_out, op_confirm_out, error_out, stall;
	cnsl_cmd_type cmd_in;
	cnsl_sdo_type sdo_in;
	cnsl_frame_type tx_frame_out;
	logic [15:0] addr_in, station_addr_out;
	logic [63:0] rpdo_in, tx_image_in, rx_image_out;
	logic [1:0] node_state_out;
	int num_errors, n_compared, bad_kind;

	cnsl_node #(.ACT_WAIT(ACT)) i_cnsl_node (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
		.addr_valid_in(addr_valid_in), .addr_in(addr_in),
		.sdo_valid_in(sdo_valid_in), .sdo_in(sdo_in),
		.rpdo_valid_in(rpdo_valid_in), .rpdo_in(rpdo_in), .sync_in(sync_in),
		.rtr_pdo_in(rtr_pdo_in), .rtr_guard_in(rtr_guard_in),
		.out_act_ok_in(out_act_ok_in), .tx_image_in(tx_image_in),
		.tx_ready_in(tx_ready_in), .tx_valid_out(tx_valid_out),
		.tx_frame_out(tx_frame_out), .rx_image_out(rx_image_out),
		.station_addr_out(station_addr_out), .node_state_out(node_state_out),
		.op_confirm_out(op_confirm_out), .error_out(error_out));
	cnsl_master_model i_cnsl_master_model (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .stall_in(stall), .tx_valid_in(tx_valid_out),
		.tx_frame_in(tx_frame_out), .tx_ready_out(tx_ready_in),
		.bad_kind_out(bad_kind));

	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic check(input logic [63:0] seen, exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %0t %s: %h vs %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(negedge clk_in);
	endtask : step
	task automatic cmd(input cnsl_cmd_type c, input logic av);
		step(1);
		cmd_in = c;
		cmd_valid_in = 1'b1;
		addr_valid_in = av;
		step(1);
		cmd_valid_in = 1'b0;
		addr_valid_in = 1'b0;
		step(2);
	endtask : cmd
	task automatic sdo(input logic [15:0] i, input logic [7:0] s,
		input logic w, input logic [31:0] v);
		step(1);
		sdo_in = {i, s, w, v};
		sdo_valid_in = 1'b1;
		step(1);
		sdo_valid_in = 1'b0;
	endtask : sdo
	task automatic pdo_in(input logic [63:0] d);
		step(1);
		rpdo_in = d;
		rpdo_valid_in = 1'b1;
		step(1);
		rpdo_valid_in = 1'b0;
	endtask : pdo_in
	task automatic poll(input logic g);
		step(1);
		if (g) rtr_guard_in = 1'b1;
		else rtr_pdo_in = 1'b1;
		step(1);
		rtr_guard_in = 1'b0;
		rtr_pdo_in = 1'b0;
	endtask : poll
	task automatic flush();
		step(20);
		i_cnsl_master_model.frames.delete();
	endtask : flush
	task automatic expect_frame(input cnsl_kind_type k,
		input logic [63:0] d, m, input int lim);
		cnsl_frame_type f;
		int n;
		n = 0;
		while (i_cnsl_master_model.frames.size() == 0 && n < lim) begin
			step(1);
			n++;
		end
		if (i_cnsl_master_model.frames.size() == 0) begin
			check(64'h1, 64'h0, "frame missing");
		end else begin
			f = i_cnsl_master_model.frames.pop_front();
			check(64'(f.kind), 64'(k), "frame kind");
			check(f.data & m, d & m, "frame data");
		end
	endtask : expect_frame
	task automatic expect_none(input int lim);
		step(lim);
		check(64'(i_cnsl_master_model.frames.size()), 64'h0, "unexpected frame");
	endtask : expect_none
	task automatic sdo_wr(input logic [15:0] i, input logic [7:0] s,
		input logic [31:0] v);
		sdo(i, s, 1'b1, v);
		expect_frame(TX_KIND_SDO, {32'h0, s, i, SDO_WR_ACK}, 64'hffffffff, 20);
	endtask : sdo_wr
	////////////////////////////////////////////////////////////////////////
	task automatic t_init();
		check(64'(node_state_out), 64'h0, "state after reset");
		sdo(OBJ_GUARD_TIME, 8'h00, 1'b0, 32'h0);
		poll(1'b1);
		expect_none(20);
		cmd(NMT_START_INPUT, 1'b0);
		check(64'(node_state_out), 64'h0, "skipped init");
	endtask : t_init
	task automatic t_preop();
		addr_in = ADDR_BASE_FIRST;
		cmd(NMT_TO_PREOP, 1'b1);
		check(64'(node_state_out), 64'h1, "preop");
		check(64'(station_addr_out), 64'(ADDR_BASE_FIRST), "address");
		cmd(NMT_START_OUTPUT, 1'b0);
		check(64'(node_state_out), 64'h1, "skipped safeop");
		poll(1'b0);
		pdo_in(64'h1122334455667788);
		expect_none(20);
		check(rx_image_out, 64'h0, "rx image in preop");
		sdo_wr(OBJ_GUARD_TIME, 8'h00, 32'h00000a0b);
		sdo(OBJ_GUARD_TIME, 8'h00, 1'b0, 32'h0);
		expect_frame(TX_KIND_SDO, {32'ha0b, 8'h0, OBJ_GUARD_TIME, SDO_RD_ACK},
			'1, 20);
		sdo(16'h5a5a, 8'h03, 1'b0, 32'h0);
		expect_frame(TX_KIND_SDO, {32'h0, 8'h03, 16'h5a5a, SDO_ERR_CODE},
			64'hffffffff, 20);
	endtask : t_preop
	task automatic t_safeop();
		cmd(NMT_START_INPUT, 1'b0);
		check(64'(node_state_out), 64'h2, "safeop");
		poll(1'b0);
		expect_none(20);
		pdo_in(64'h0f0e0d0c0b0a0908);
		step(2);
		check(rx_image_out, 64'h0, "rx image in safeop");
		sdo(OBJ_GUARD_TIME, 8'h00, 1'b0, 32'h0);
		expect_frame(TX_KIND_SDO, {32'ha0b, 8'h0, OBJ_GUARD_TIME, SDO_RD_ACK},
			'1, 20);
	endtask : t_safeop
	task automatic t_activate();
		out_act_ok_in = 1'b0;
		cmd(NMT_START_OUTPUT, 1'b0);
		step(ACT + 10);
		check(64'(node_state_out), 64'h2, "stayed safeop");
		check(64'(error_out), 64'h1, "error flag");
		out_act_ok_in = 1'b1;
		cmd(NMT_START_OUTPUT, 1'b0);
		step(2);
		check(64'(node_state_out), 64'h3, "operational");
		check(64'(op_confirm_out), 64'h0, "early confirm");
		pdo_in(64'hdeadbeefcafe0123);
		step(3);
		check(64'(op_confirm_out), 64'h1, "confirm");
		check(rx_image_out, 64'hdeadbeefcafe0123, "rx image");
	endtask : t_activate
	task automatic t_modes();
		flush();
		tx_image_in = 64'h0102030405060708;
		expect_frame(TX_KIND_PDO, tx_image_in, '1, 20);
		poll(1'b0);
		expect_frame(TX_KIND_PDO, 64'h0102030405060708, '1, 20);
		sdo_wr(OBJ_TPDO_PAR_LO, 8'h02, 32'h1);
		flush();
		tx_image_in = 64'ha1a2a3a4a5a6a7a8;
		expect_none(10);
		step(1);
		sync_in = 1'b1;
		step(1);
		sync_in = 1'b0;
		tx_image_in = 64'hb1b2b3b4b5b6b7b8;
		expect_frame(TX_KIND_PDO, 64'ha1a2a3a4a5a6a7a8, '1, 20);
		sdo_wr(OBJ_TPDO_PAR_LO, 8'h05, 32'h2);
		sdo_wr(OBJ_TPDO_PAR_LO, 8'h02, 32'h2);
		flush();
		expect_frame(TX_KIND_PDO, tx_image_in, '1, 450);
		sdo_wr(OBJ_TPDO_PAR_LO, 8'h02, 32'h3);
		flush();
		sdo_wr(OBJ_HEARTBEAT, 8'h00, 32'h2);
		expect_frame(TX_KIND_STATE, 64'h05, '1, 450);
		sdo_wr(OBJ_HEARTBEAT, 8'h00, 32'h0);
		flush();
		poll(1'b1);
		expect_frame(TX_KIND_STATE, 64'h05, '1, 20);
	endtask : t_modes
	task automatic t_stall();
		// Receiver stalls: both words must wait in the buffer
		stall = 1'b1;
		step(2);
		poll(1'b0);
		poll(1'b1);
		step(10);
		check(64'(tx_valid_out), 64'h1, "held frame");
		check(64'(i_cnsl_master_model.frames.size()), 64'h0, "leak");
		stall = 1'b0;
		expect_frame(TX_KIND_PDO, tx_image_in, '1, 20);
		// Second accepted guard answer carries the toggle bit set
		expect_frame(TX_KIND_STATE, 64'h85, '1, 20);
		cmd(NMT_RESET_NODE, 1'b0);
		check(64'(node_state_out), 64'h0, "reset node");
	endtask : t_stall
	////////////////////////////////////////////////////////////////////////
	initial begin
		{cmd_valid_in, addr_valid_in, sdo_valid_in, rpdo_valid_in} = '0;
		{sync_in, rtr_pdo_in, rtr_guard_in, out_act_ok_in, stall} = '0;
		cmd_in = NMT_NONE;
		sdo_in = '0;
		addr_in = 16'h0000;
		rpdo_in = 64'h0;
		tx_image_in = 64'h0;
		num_errors = 0;
		n_compared = 0;
		reset_n_in = 1'b0;
		step(8);
		reset_n_in = 1'b1;
		t_init();
		t_preop();
		t_safeop();
		t_activate();
		t_modes();
		t_stall();
		check(64'(bad_kind), 64'h0, "master traffic");
		stop_test();
	end
	// Run needs under 10 us; generous margin
	initial begin
		#200us;
		num_errors++;
		stop_test();
	end
endmodule : tb_cnsl_node
